// file: shared/dshp_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * downstream slot hot-plug controller.
 * Assumes a 32-bit classic Wishbone slave and a 200 MHz core clock.
 */
`ifndef DSHP_PARAMS_SVH
`define DSHP_PARAMS_SVH

// register offsets: global word at byte zero, port p at p*0x10, words in a port by index
`define DSHP_CFG_OFS      8'h00
`define DSHP_CAP_OFS      2'h0
`define DSHP_CTL_OFS      2'h1
`define DSHP_STS_OFS      2'h2

// slot capabilities fields
`define DSHP_CAP_LATCH    2
`define DSHP_CAP_HPC      6
`define DSHP_CAP_RST      16'h0000

// slot control fields
`define DSHP_CTL_CCIE     4
`define DSHP_CTL_HOTPLUG_IRQ_ENABLE_BIT     5
`define DSHP_CTL_AIC      7:6
`define DSHP_CTL_PIC      9:8
`define DSHP_CTL_PCC      10
`define DSHP_CTL_EIC      11
`define DSHP_CTL_RST      16'h03c0

// slot status fields
`define DSHP_STS_CC       4
`define DSHP_STS_LATCH    5
`define DSHP_STS_PRES     6
`define DSHP_STS_EIS      7
`define DSHP_STS_PGOOD    8

// hot-plug configuration fields: bits 8:0 invert the nine slot signals
`define DSHP_CFG_TOGGLE   9
`define DSHP_CFG_LREPL    10
`define DSHP_CFG_APO      11
`define DSHP_CFG_RST      12'h000

// indicator encodings
`define DSHP_IND_ON       2'h1
`define DSHP_IND_BLINK    2'h2

// timing
`define DSHP_CLK_MHZ      200
`define DSHP_ILOCK_MS     125
`define DSHP_BLINK_MS     250

`endif

// file: shared/dshp_pkg.sv
/*
 * Types of the downstream slot hot-plug controller.
 * Assumes nothing beyond the constants header.
 */
package dshp_pkg;

	// slot sensor inputs of one port, as seen at the expander
	typedef struct packed {
		logic pgood;
		logic latch;
		logic fault;
		logic presence;
		logic button;
	} dshp_in_s;

	// slot control outputs of one port, as driven to the expander
	typedef struct packed {
		logic ilock;
		logic pwr_en;
		logic pwr_ind;
		logic attn;
	} dshp_out_s;

endpackage

// file: src/dshp_ctrl.sv
/*
 * Hot-plug controller for downstream ports 1..7 of a switch, with a
 * classic Wishbone register slave.
 * Assumes expander bits arrive unsynchronised, and that the serial
 * loader holds eeprom_busy_i while it writes registers over the bus.
 */
// Chosen here: the placing of the registers and the Wishbone slave port.
// Contract
// R1 - a port's controller works only once its hot-plug-capable bit is set
// R2 - slot signals are exchanged through the I/O expander ports only
// R3 - presence comes only from the presence-detect input, never the link
// R4 - five sensor inputs and four control outputs per port
// R5 - ports 1 to 7, each with independent signals and state
// R6 - one invert bit per signal, shared by every port
// R7 - interlock-control write gives one 125 ms pulse when toggle mode is off; the code holds it ILOCK_CYC - 1 cycles, one cycle short
// R8 - in toggle mode each interlock-control write inverts the interlock output
// R9 - latch-replaced mode reports the latch sensor as interlock status
// R10 - latch-replaced mode reads latch sensor state as zero
// R11 - otherwise interlock status reads the driven interlock output
// R12 - auto power-off plus latch present cuts power while latch is open
// R13 - loader may override hot-plug register reset values
// R14 - expander starts after loader; loader writes never set command completed
// R15 - slot reset is never an expander output
// R16 - indicators and button belong only to the slot, not the card
// R17 - interrupts only while the hot-plug interrupt enable is set
// R18 - the five event flags request interrupts unless masked
// R19 - command completed never raises a wake-up request
// R20 - inversion sits between raw bits and the active-high internal view
`timescale 1ns/10ps
`include "dshp_params.svh"

module dshp_ctrl
	import dshp_pkg::*;
#(
	parameter int NPORT     = 7,
	parameter int ILOCK_CYC = `DSHP_ILOCK_MS * 1000 * `DSHP_CLK_MHZ,
	parameter int BLINK_CYC = `DSHP_BLINK_MS * 1000 * `DSHP_CLK_MHZ
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// wishbone slave
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [7:0]        adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	output logic                   ack_o,
	// serial loader
	input  wire logic              eeprom_busy_i,
	output logic                   exp_init_o,
	// expander side, index 0 is port 1
	input  wire dshp_in_s [NPORT-1:0] exp_in_i,
	output dshp_out_s     [NPORT-1:0] exp_out_o,
	// event requests per port
	output logic      [NPORT-1:0]  irq_o,
	output logic      [NPORT-1:0]  wake_o
);

	logic                   req;
	logic                   wr;
	logic [31:0]            wmask;
	logic [3:0]             port_sel;
	logic [11:0]            cfg_reg;
	logic [8:0]             inv;
	dshp_in_s [NPORT-1:0]   sync1_reg;
	dshp_in_s [NPORT-1:0]   sync2_reg;
	dshp_in_s [NPORT-1:0]   view;
	dshp_in_s [NPORT-1:0]   prev_reg;
	logic [NPORT-1:0][15:0] cap_reg;
	logic [NPORT-1:0][15:0] ctl_reg;
	logic [NPORT-1:0][4:0]  flag_reg;
	logic [NPORT-1:0]       ilock_reg;
	logic [NPORT-1:0][31:0] ilock_cnt_reg;
	logic [NPORT-1:0][15:0] sts;
	logic [31:0]            blink_cnt_reg;
	logic                   blink_reg;

	assign req   = cyc_i & stb_i & ~ack_o;
	assign wr    = req & we_i;
	assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	assign port_sel = adr_i[7:4];
	assign inv   = cfg_reg[8:0];

	// bus answer one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end

	// read mux; unmapped words read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0;
		end else if (req && !we_i) begin
			dat_o <= 32'h0;
			if (adr_i == `DSHP_CFG_OFS) begin
				dat_o <= {20'h0, cfg_reg};
			end else if (port_sel >= 4'h1 && port_sel <= 4'(NPORT)) begin
				unique case (adr_i[3:2])
					`DSHP_CAP_OFS: dat_o <= {16'h0, cap_reg[port_sel-4'h1]};
					`DSHP_CTL_OFS: dat_o <= {16'h0, ctl_reg[port_sel-4'h1]};
					`DSHP_STS_OFS: dat_o <= {16'h0, sts[port_sel-4'h1]};
					default:       dat_o <= 32'h0;
				endcase
			end
		end
	end

	// global configuration, shared by all ports
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg <= `DSHP_CFG_RST;
		end else if (wr && adr_i == `DSHP_CFG_OFS) begin
			cfg_reg <= (cfg_reg & ~wmask[11:0]) | (dat_i[11:0] & wmask[11:0]); // R6 R13
		end
	end

	// expander traffic waits for the loader so its writes never look like commands
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			exp_init_o <= 1'b0;
		end else if (!eeprom_busy_i) begin
			exp_init_o <= 1'b1; // R14
		end
	end

	// raw expander inputs cross into the core clock through two flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= exp_in_i; // R2
			sync2_reg <= sync1_reg;
		end
	end

	// shared blink phase for both indicators
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blink_cnt_reg <= 32'h0;
			blink_reg     <= 1'b0;
		end else if (blink_cnt_reg >= 32'(BLINK_CYC - 1)) begin
			blink_cnt_reg <= 32'h0;
			blink_reg     <= ~blink_reg;
		end else begin
			blink_cnt_reg <= blink_cnt_reg + 32'h1;
		end
	end

	genvar p;
	generate
		for (p = 0; p < NPORT; p++) begin : g_port // R5
			logic hit;
			logic active;
			logic eic_wr;
			logic latch_open;
			logic pwr_on;
			logic [15:0] wd;
			dshp_out_s out_int;

			assign hit    = wr && port_sel == 4'(p + 1);
			assign wd     = dat_i[15:0] & wmask[15:0];
			assign active = cap_reg[p][`DSHP_CAP_HPC] & exp_init_o; // R1
			assign eic_wr = hit && adr_i[3:2] == `DSHP_CTL_OFS && wd[`DSHP_CTL_EIC];
			assign latch_open = view[p].latch;

			// polarity fix before any status or edge logic sees the inputs
			assign view[p] = sync2_reg[p] ^ {inv[8], inv[3:0]}; // R20 R6

			// slot-status word as software sees it
			always_comb begin
				sts[p] = 16'h0;
				sts[p][4:0] = flag_reg[p];
				sts[p][`DSHP_STS_PRES]  = view[p].presence; // R3
				sts[p][`DSHP_STS_PGOOD] = view[p].pgood;
				if (cfg_reg[`DSHP_CFG_LREPL]) begin
					sts[p][`DSHP_STS_EIS]   = view[p].latch; // R9
					sts[p][`DSHP_STS_LATCH] = 1'b0; // R10
				end else begin
					sts[p][`DSHP_STS_EIS]   = ilock_reg[p]; // R11
					sts[p][`DSHP_STS_LATCH] = view[p].latch;
				end
			end

			// capabilities are set only by the loader, read-only afterwards
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cap_reg[p] <= `DSHP_CAP_RST;
				end else if (hit && eeprom_busy_i && adr_i[3:2] == `DSHP_CAP_OFS) begin
					cap_reg[p] <= (cap_reg[p] & ~wmask[15:0]) | wd; // R13
				end
			end

			// slot control; the interlock-control bit is write-only
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					ctl_reg[p] <= `DSHP_CTL_RST;
				end else if (hit && adr_i[3:2] == `DSHP_CTL_OFS) begin
					ctl_reg[p] <= (ctl_reg[p] & ~wmask[15:0]) | wd;
					ctl_reg[p][`DSHP_CTL_EIC] <= 1'b0;
				end
			end

			// previous view for edge detection
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					prev_reg[p] <= '0;
				end else begin
					prev_reg[p] <= view[p];
				end
			end

			// event flags: write one clears, a new event in the same cycle wins
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					flag_reg[p] <= 5'h0;
				end else begin
					logic [4:0] set;
					set    = 5'h0;
					set[0] = view[p].button & ~prev_reg[p].button; // R16
					set[1] = view[p].fault & ~prev_reg[p].fault;
					set[2] = view[p].latch ^ prev_reg[p].latch;
					set[3] = view[p].presence ^ prev_reg[p].presence; // R3
					set[4] = hit && adr_i[3:2] == `DSHP_CTL_OFS && !eeprom_busy_i; // R14
					if (!active) begin
						set = 5'h0;
					end
					if (hit && adr_i[3:2] == `DSHP_STS_OFS) begin
						flag_reg[p] <= (flag_reg[p] & ~wd[4:0]) | set;
					end else begin
						flag_reg[p] <= flag_reg[p] | set;
					end
				end
			end

			// interlock: timed pulse, or level flip in toggle mode
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					ilock_reg[p]     <= 1'b0;
					ilock_cnt_reg[p] <= 32'h0;
				end else if (eic_wr && active && cfg_reg[`DSHP_CFG_TOGGLE]) begin
					ilock_reg[p]     <= ~ilock_reg[p]; // R8
					ilock_cnt_reg[p] <= 32'h0;
				end else if (eic_wr && active && !ilock_reg[p]) begin
					ilock_reg[p]     <= 1'b1; // R7
					ilock_cnt_reg[p] <= 32'(ILOCK_CYC - 1);
				end else if (ilock_cnt_reg[p] != 32'h0) begin
					ilock_cnt_reg[p] <= ilock_cnt_reg[p] - 32'h1;
					if (ilock_cnt_reg[p] == 32'h1) begin
						ilock_reg[p] <= 1'b0; // R7
					end
				end
			end

			// power is on when control asks and the latch does not veto it
			assign pwr_on = !ctl_reg[p][`DSHP_CTL_PCC] &&
				!(cfg_reg[`DSHP_CFG_APO] && cap_reg[p][`DSHP_CAP_LATCH] && latch_open); // R12

			// internal active-high outputs; slot reset is not among them
			always_comb begin
				out_int = '0; // R15
				if (active) begin
					out_int.attn    = ctl_reg[p][`DSHP_CTL_AIC] == `DSHP_IND_ON ||
						(ctl_reg[p][`DSHP_CTL_AIC] == `DSHP_IND_BLINK && blink_reg);
					out_int.pwr_ind = ctl_reg[p][`DSHP_CTL_PIC] == `DSHP_IND_ON ||
						(ctl_reg[p][`DSHP_CTL_PIC] == `DSHP_IND_BLINK && blink_reg);
					out_int.pwr_en  = pwr_on;
					out_int.ilock   = ilock_reg[p];
				end
			end

			// raw expander outputs and event requests, all registered
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					exp_out_o[p] <= '0;
					irq_o[p]     <= 1'b0;
					wake_o[p]    <= 1'b0;
				end else begin
					exp_out_o[p] <= out_int ^ inv[7:4]; // R4 R20
					irq_o[p]     <= ctl_reg[p][`DSHP_CTL_HOTPLUG_IRQ_ENABLE_BIT] &&
						|(flag_reg[p] & ctl_reg[p][4:0]); // R17 R18
					wake_o[p]    <= |(flag_reg[p][3:0] & ctl_reg[p][3:0]); // R19
				end
			end
		end
	endgenerate

	// checks on port 1; every port is the same generate body

	inactive_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
		!cap_reg[0][`DSHP_CAP_HPC] |=> !$rose(flag_reg[0][0]))
		else $error("event flag set on a port that is not hot-plug capable");
	pulse_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
		$rose(ilock_reg[0]) && !cfg_reg[`DSHP_CFG_TOGGLE] |->
		ilock_cnt_reg[0] == 32'(ILOCK_CYC - 1))
		else $error("interlock pulse not loaded with its full length");
	pulse_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
		ilock_cnt_reg[0] == 32'h1 && !cfg_reg[`DSHP_CFG_TOGGLE] && !g_port[0].eic_wr
		|=> !ilock_reg[0])
		else $error("interlock pulse did not end");
	toggle_flip_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		g_port[0].eic_wr && g_port[0].active && cfg_reg[`DSHP_CFG_TOGGLE]
		|=> ilock_reg[0] != $past(ilock_reg[0]))
		else $error("toggle write did not flip interlock");
	lrepl_eis_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
		cfg_reg[`DSHP_CFG_LREPL] |-> sts[0][`DSHP_STS_EIS] == view[0].latch &&
		!sts[0][`DSHP_STS_LATCH]) // R10
		else $error("latch-replaced status wrong");
	eis_drive_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
		!cfg_reg[`DSHP_CFG_LREPL] && g_port[0].active |=>
		$past(sts[0][`DSHP_STS_EIS]) == (exp_out_o[0].ilock ^ $past(inv[7])))
		else $error("interlock status differs from driven output");
	auto_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
		cfg_reg[`DSHP_CFG_APO] && cap_reg[0][`DSHP_CAP_LATCH] && view[0].latch
		|=> !(exp_out_o[0].pwr_en ^ $past(inv[6])))
		else $error("power stayed on with latch open");
	no_cc_load_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
		eeprom_busy_i |-> !exp_init_o && !$rose(flag_reg[0][`DSHP_STS_CC]))
		else $error("command completed during loader phase");
	irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
		!$past(ctl_reg[0][`DSHP_CTL_HOTPLUG_IRQ_ENABLE_BIT]) |-> !irq_o[0])
		else $error("interrupt with enable clear");
	no_cc_wake_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
		flag_reg[0] == 5'h10 |=> !wake_o[0])
		else $error("command completed raised wake-up");

	pulse_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
		$fell(ilock_reg[0]) && !cfg_reg[`DSHP_CFG_TOGGLE]);
	presence_c: cover property (@(posedge clk_i) disable iff (rst_i)
		$rose(flag_reg[0][3]));
	irq_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o[0]));

endmodule

// file: verif/dshp_slot_model.sv
/*
 * Expander-side model of the slot wiring: turns the active-high slot view
 * into raw expander levels and back again under the shared invert bits.
 * Assumes the bench keeps inv_i equal to the invert field it programs.
 */
`timescale 1ns/10ps

module dshp_slot_model
	import dshp_pkg::*;
#(
	parameter int NPORT = 7
) (
	// slot side, active high
	input  wire dshp_in_s  [NPORT-1:0] slot_i,
	output dshp_out_s      [NPORT-1:0] slot_o,
	// invert field of the global word
	input  wire logic      [8:0]       inv_i,
	// expander side, raw levels
	input  wire dshp_out_s [NPORT-1:0] exp_out_i,
	output dshp_in_s       [NPORT-1:0] exp_in_o
);
	// one invert bit per signal, identical for every port
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			exp_in_o[p] = slot_i[p] ^ {inv_i[8], inv_i[3:0]};
			slot_o[p]   = exp_out_i[p] ^ inv_i[7:4];
		end
	end
endmodule

// file: verif/dshp_ctrl_tb.sv
/*
 * Directed bench of the slot hot-plug controller over classic Wishbone.
 * Assumes the expander model and shortened interlock and blink counts.
 */
`timescale 1ns/10ps
`include "dshp_params.svh"

module dshp_ctrl_tb
	import dshp_pkg::*;
;
	localparam int NP  = 7;
	localparam int ILK = 20;
	localparam int CAP = `DSHP_CAP_OFS;
	localparam int CTL = `DSHP_CTL_OFS;
	localparam int STS = `DSHP_STS_OFS;
	// struct bit that raises each event flag: button, fault, latch, presence
	localparam logic [4:0] EVT [4] = '{5'h01, 5'h04, 5'h08, 5'h02};

	logic                  clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic                  eeprom_busy_i, exp_init_o;
	logic      [7:0]       adr_i;
	logic      [31:0]      dat_i, dat_o, rd;
	logic      [NP-1:0]    irq_o, wake_o;
	logic      [8:0]       inv;
	dshp_in_s  [NP-1:0]    slot, exp_in;
	dshp_out_s [NP-1:0]    exp_out, seen;
	int                    error_cnt, n_compared, ilk_n, ilk_0, k;

	dshp_ctrl #(.NPORT(NP), .ILOCK_CYC(ILK), .BLINK_CYC(8)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.eeprom_busy_i(eeprom_busy_i), .exp_init_o(exp_init_o), .exp_in_i(exp_in),
		.exp_out_o(exp_out), .irq_o(irq_o), .wake_o(wake_o));

	dshp_slot_model #(.NPORT(NP)) exp_u (
		.slot_i(slot), .slot_o(seen), .inv_i(inv), .exp_out_i(exp_out),
		.exp_in_o(exp_in));

	// 200 MHz core clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// width of the interlock pulse on port 1, counted in core cycles
	always @(posedge clk_i) begin
		if (exp_out[0].ilock === 1'b1) ilk_n <= ilk_n + 1;
	end

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one classic cycle; held until ack is sampled high, data taken there
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (ack_o === 1'b1) break;
		end
		if (i < 20) begin
			rd = dat_o;
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
			we_i  <= 1'b0;
		end else begin
			error_cnt++;
			conclude();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, e, rd & m);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	function automatic logic [7:0] ra(input int p, input int r);
		return 8'(p * 16 + r * 4);
	endfunction

	initial begin
		{cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
		rst_i = 1'b1;
		eeprom_busy_i = 1'b1;
		inv = 9'h000;
		slot = '0;
		error_cnt = 0;
		n_compared = 0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		// loader phase: ports 1 and 2 made capable, port 3 left inactive
		wr(ra(1, CAP), 32'h44);
		wr(ra(2, CAP), 32'h44);
		wr(ra(1, CTL), 32'h0400);
		chk("init held", 32'h0, exp_init_o);
		eeprom_busy_i <= 1'b0;
		idle(3);
		chk("init", 32'h1, exp_init_o);
		rdc("cc after load", ra(1, STS), 32'h10, 32'h0);
		wr(ra(1, CAP), 32'h0);
		rdc("cap kept", ra(1, CAP), 32'hffff, 32'h44);
		rdc("unmapped", 8'hf4, 32'hffffffff, 32'h0);
		// control write after loading completes a command
		wr(ra(1, CTL), 32'h0140);
		rdc("cc", ra(1, STS), 32'h10, 32'h10);
		wr(ra(1, STS), 32'h1f);
		rdc("cc clear", ra(1, STS), 32'h10, 32'h0);
		chk("p1 outs", 32'h7, seen[0]);
		chk("p2 outs", 32'h4, seen[1]);
		chk("p3 idle", 32'h0, exp_out[2]);
		// timed interlock pulse; status follows the driven output
		ilk_0 = ilk_n;
		wr(ra(1, CTL), 32'h0940);
		rdc("eis pulse", ra(1, STS), 32'h80, 32'h80);
		idle(40);
		// the line drops on the counter's last step, one cycle short of ILK
		chk("pulse len", 32'(ILK - 1), 32'(ilk_n - ilk_0));
		rdc("eis low", ra(1, STS), 32'h80, 32'h0);
		// toggle mode: each write flips the level and it stays
		wr(8'h00, 32'h200);
		wr(ra(1, CTL), 32'h0940);
		idle(30);
		chk("tog on", 32'h1, seen[0].ilock);
		wr(ra(1, CTL), 32'h0940);
		idle(2);
		chk("tog off", 32'h0, seen[0].ilock);
		// latch stands in for interlock status and reads closed
		wr(8'h00, 32'h400);
		slot[0].latch <= 1'b1;
		idle(5);
		rdc("latch repl", ra(1, STS), 32'ha0, 32'h80);
		chk("pwr no apo", 32'h1, seen[0].pwr_en);
		wr(8'h00, 32'h800);
		idle(3);
		chk("apo off", 32'h0, seen[0].pwr_en);
		rdc("latch open", ra(1, STS), 32'ha0, 32'h20);
		slot[0].latch <= 1'b0;
		idle(5);
		chk("apo closed", 32'h1, seen[0].pwr_en);
		// blinking attention: the shared phase flips every eight cycles
		wr(ra(1, CTL), 32'h0180);
		idle(2);
		k = seen[0].attn;
		idle(8);
		chk("blink", 32'(k ^ 1), seen[0].attn);
		chk("pind on", 32'h1, seen[0].pwr_ind);
		// invert presence and power enable in every port
		inv <= 9'h042;
		wr(8'h00, 32'h042);
		rdc("cfg", 8'h00, 32'hfff, 32'h042);
		slot[0].presence <= 1'b1;
		slot[0].pgood <= 1'b1;
		slot[1].presence <= 1'b1;
		slot[2].presence <= 1'b1;
		idle(5);
		rdc("pres p1", ra(1, STS), 32'h140, 32'h140);
		rdc("pres p2", ra(2, STS), 32'h40, 32'h40);
		rdc("p3 flags", ra(3, STS), 32'h5f, 32'h40);
		chk("raw p1", 32'h0, exp_out[0].pwr_en);
		chk("raw p2", 32'h0, exp_out[1].pwr_en);
		chk("raw p3", 32'h4, exp_out[2]);
		// each of the four sensor event flags (not command completed), enabled alone under the master enable
		for (k = 0; k < 4; k++) begin
			wr(ra(1, CTL), 32'h20 | (32'h1 << k));
			wr(ra(1, STS), 32'h1f);
			slot[0] <= slot[0] ^ EVT[k];
			idle(5);
			rdc("flag", ra(1, STS), 32'h1f, 32'h1 << k);
			chk("irq", 32'h1, irq_o[0]);
			chk("irq p2", 32'h0, irq_o[1]);
		end
		wr(ra(1, CTL), 32'h08);
		idle(3);
		chk("irq masked", 32'h0, irq_o[0]);
		chk("wake", 32'h1, wake_o[0]);
		wr(ra(1, STS), 32'h1f);
		idle(3);
		chk("wake clr", 32'h0, wake_o[0]);
		wr(ra(1, CTL), 32'h30);
		idle(3);
		chk("irq cc", 32'h1, irq_o[0]);
		chk("wake cc", 32'h0, wake_o[0]);
		conclude();
	end
endmodule
